/* rtl/dcl_ctrl.sv */
// Delay-lock controller with its serial configuration registers
// Functional notes
// - Enable set runs closed loop from phase feedback; clear uses setpoints directly.
// - Read-only fail flag, status bit 2, set when lock cannot be achieved.
// - Lost-lock flag, status bit 1, set on dropping out of lock; cleared by writing zero.
// - Read-only locked flag, status bit 0, high while lock held; flags reset zero.
// - Six-bit coarse setpoint, reset zero, selects coarse delay.
// - Eight-bit fine setpoint, reset mid-scale, selects fine delay.
// - Three-bit filter bandwidth field smooths phase measurements, resets zero.
// - Request rising edge captures live coarse, fine and phase into readbacks.
// - Captured coarse value readable in read-only register, reset zero.
// - Captured fine value readable in eight-bit read-only register, reset zero.
`timescale 1ns/1ps
module dcl_ctrl
    import dcl_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Serial configuration port
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_o,
    // Phase detector feedback, 0 to 16
    input  wire logic [4:0] phase_meas_i,
    // Delay line controls
    output logic [5:0]      coarse_delay_o,
    output logic [7:0]      fine_delay_o,
    output logic            locked_o
);
    // Registers
    logic [7:0]  loop_control_q;
    logic        lost_q;
    logic        fail_q;
    logic [3:0]  guard_q;
    logic [5:0]  coarse_set_q;
    logic [7:0]  fine_set_q;
    logic [4:0]  desired_phase_q;
    logic [2:0]  phase_filter_bandwidth_q;
    logic [1:0]  tracking_speed_q;
    logic        rb_req_q;
    logic [5:0]  coarse_delay_readback_q;
    logic [7:0]  fine_delay_readback_q;
    logic [4:0]  phase_readback_value_q;

    // Serial port state
    logic        sclk_prev_q;
    logic [4:0]  bit_cnt_q;
    logic [15:0] instr_q;
    logic [7:0]  wdata_q;
    logic [7:0]  rsh_q;
    logic        wr_stb;
    logic [7:0]  wr_data;
    logic [14:0] wr_addr;
    logic [7:0]  rdata;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        is_read;

    assign sclk_rise = !spi_cs_n_i && spi_sclk_i && !sclk_prev_q;
    assign sclk_fall = !spi_cs_n_i && !spi_sclk_i && sclk_prev_q;
    assign is_read   = instr_q[15];
    assign wr_data   = {wdata_q[6:0], spi_sdi_i};
    assign wr_addr   = instr_q[14:0];
    assign wr_stb    = sclk_rise && (bit_cnt_q == SPI_LAST_DATA_BIT) && !is_read;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_prev_q <= 1'b0;
            bit_cnt_q   <= 5'h00;
            instr_q     <= 16'h0000;
            wdata_q     <= 8'h00;
        end else begin
            sclk_prev_q <= spi_sclk_i;
            if (spi_cs_n_i) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_rise) begin
                if (bit_cnt_q <= SPI_LAST_INSTR_BIT) begin
                    instr_q <= {instr_q[14:0], spi_sdi_i};
                end else begin
                    wdata_q <= wr_data;
                end
                if (bit_cnt_q != SPI_LAST_DATA_BIT) begin
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
            end
        end
    end

    // Read data; reserved bits read as zero
    always_comb begin
        unique case ({instr_q[13:0], spi_sdi_i})
            ADDR_LOOP_CONTROL:      rdata = loop_control_q;
            ADDR_LOCK_STATUS:       rdata = {5'h00, fail_q, lost_q, locked_o};
            ADDR_SEARCH_GUARD_BAND: rdata = {4'h0, guard_q};
            ADDR_COARSE_SETPOINT:   rdata = {2'h0, coarse_set_q};
            ADDR_FINE_SETPOINT:     rdata = fine_set_q;
            ADDR_TARGET_PHASE:      rdata = {3'h0, desired_phase_q};
            ADDR_LOOP_BANDWIDTH:    rdata = {3'h0, phase_filter_bandwidth_q, tracking_speed_q};
            ADDR_READBACK_REQUEST:  rdata = {7'h00, rb_req_q};
            ADDR_COARSE_READBACK:   rdata = {2'h0, coarse_delay_readback_q};
            ADDR_FINE_READBACK:     rdata = fine_delay_readback_q;
            ADDR_PHASE_READBACK:    rdata = {3'h0, phase_readback_value_q};
            default:                rdata = 8'h00;
        endcase
    end

    // Read data is loaded at the last instruction bit and driven out on falling edges
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rsh_q        <= 8'h00;
            spi_sdo_o    <= 1'b0;
            spi_sdo_oe_o <= 1'b0;
        end else if (spi_cs_n_i) begin
            spi_sdo_oe_o <= 1'b0;
        end else if (sclk_rise && bit_cnt_q == SPI_LAST_INSTR_BIT && instr_q[14]) begin
            rsh_q <= rdata;
        end else if (sclk_fall && bit_cnt_q > SPI_LAST_INSTR_BIT && is_read) begin
            spi_sdo_o    <= rsh_q[7];
            spi_sdo_oe_o <= 1'b1;
            rsh_q        <= {rsh_q[6:0], 1'b0};
        end
    end

    // Software-written registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            loop_control_q           <= RST_LOOP_CONTROL;
            guard_q                  <= RST_ZERO[3:0];
            coarse_set_q             <= RST_ZERO[5:0];
            fine_set_q               <= RST_FINE_SETPOINT;
            desired_phase_q          <= RST_DESIRED_PHASE;
            phase_filter_bandwidth_q <= RST_ZERO[2:0];
            tracking_speed_q         <= RST_ZERO[1:0];
            rb_req_q                 <= 1'b0;
        end else if (wr_stb) begin
            case (wr_addr)
                ADDR_LOOP_CONTROL:      loop_control_q  <= wr_data;
                ADDR_SEARCH_GUARD_BAND: guard_q         <= wr_data[3:0];
                ADDR_COARSE_SETPOINT:   coarse_set_q    <= wr_data[5:0];
                ADDR_FINE_SETPOINT:     fine_set_q      <= wr_data;
                ADDR_TARGET_PHASE:      desired_phase_q <= wr_data[4:0];
                ADDR_LOOP_BANDWIDTH: begin
                    phase_filter_bandwidth_q <= wr_data[BW_FILT_LSB +: 3];
                    tracking_speed_q         <= wr_data[BW_WEIGHT_LSB +: 2];
                end
                ADDR_READBACK_REQUEST:  rb_req_q        <= wr_data[0];
                default:                ;
            endcase
        end
    end

    // Phase filter: first-order smoothing with three fractional bits
    logic [7:0]        filt_q;
    logic signed [8:0] filt_diff;
    logic [4:0]        phase_now;
    assign filt_diff = $signed({1'b0, phase_meas_i, 3'b000}) - $signed({1'b0, filt_q});
    assign phase_now = filt_q[7:3];

    // Update-rate divider
    logic [3:0] div_q;
    logic       tick;
    assign tick = (div_q == UPDATE_DIV_CYC - 4'h1);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_q  <= 4'h0;
            filt_q <= {RST_DESIRED_PHASE, 3'b000};
        end else begin
            div_q  <= tick ? 4'h0 : div_q + 4'h1;
            // Shift is widened so the top bandwidth setting does not wrap to no smoothing
            filt_q <= filt_q + 8'(filt_diff >>> (4'(phase_filter_bandwidth_q) + 4'h1));
        end
    end

    // Loop error and decisions
    logic              enable;
    logic [1:0]        mode;
    logic signed [5:0] err;
    logic [4:0]        err_abs;
    logic              in_band;
    logic              step_up;
    logic [7:0]        fine_step;
    assign enable    = loop_control_q[CTL_ENABLE_BIT];
    assign mode      = loop_control_q[CTL_MODE_LSB +: 2];
    assign err       = $signed({1'b0, phase_now}) - $signed({1'b0, desired_phase_q});
    assign err_abs   = err[5] ? 5'(-err) : err[4:0];
    assign in_band   = err_abs <= {1'b0, guard_q};
    // Slope selects which side of the target lengthens the delay
    assign step_up   = err[5] ^ !loop_control_q[CTL_SLOPE_BIT];
    assign fine_step = 8'h01 << tracking_speed_q;

    dcl_state_e  state_q;
    logic [5:0]  coarse_q;
    logic [7:0]  fine_q;
    logic        down_q;
    logic        lost_evt;
    logic        lost_clr;

    // Controller sequencing; search sweeps coarse, track trims fine
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q  <= ST_IDLE;
            coarse_q <= RST_ZERO[5:0];
            fine_q   <= RST_FINE_SETPOINT;
            down_q   <= 1'b0;
            locked_o <= 1'b0;
            fail_q   <= 1'b0;
        end else if (!enable) begin
            // Open loop: delay lines follow the setpoints
            state_q  <= ST_IDLE;
            coarse_q <= coarse_set_q;
            fine_q   <= fine_set_q;
            locked_o <= 1'b0;
        end else if (tick) begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= (mode == MODE_TRACK_ONLY) ? ST_TRACK : ST_SEARCH;
                    down_q  <= loop_control_q[CTL_SEARCH_LSB];
                end
                ST_SEARCH: begin
                    // Search-only mode stays here, so lock must also drop here
                    locked_o <= in_band;
                    if (in_band) begin
                        fail_q   <= 1'b0;
                        if (mode != MODE_SEARCH_ONLY) begin
                            state_q <= ST_TRACK;
                        end
                    end else if ((down_q && coarse_q == 6'h00) ||
                                 (!down_q && coarse_q == COARSE_MAX)) begin
                        fail_q  <= 1'b1;
                        if (loop_control_q[CTL_SEARCH_ERR_BIT]) begin
                            coarse_q <= coarse_set_q;
                        end else begin
                            state_q <= ST_FAIL;
                        end
                    end else begin
                        coarse_q <= down_q ? coarse_q - 6'h01 : coarse_q + 6'h01;
                    end
                end
                ST_TRACK: begin
                    locked_o <= in_band;
                    if (!in_band && loop_control_q[CTL_TRACK_ERR_BIT]) begin
                        state_q <= ST_SEARCH;
                    end else if (!in_band) begin
                        fine_q <= step_up ? fine_q + fine_step : fine_q - fine_step;
                    end
                end
                ST_FAIL: state_q <= ST_FAIL;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Lost lock is sticky; a new loss wins over a software clear in the same cycle
    assign lost_evt = tick && locked_o && !in_band && enable &&
                      (state_q == ST_TRACK || state_q == ST_SEARCH);
    assign lost_clr = wr_stb && wr_addr == ADDR_LOCK_STATUS && !wr_data[STS_LOST_BIT];

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lost_q <= 1'b0;
        end else if (lost_evt) begin
            lost_q <= 1'b1;
        end else if (lost_clr) begin
            lost_q <= 1'b0;
        end
    end

    // Delay line outputs
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            coarse_delay_o <= RST_ZERO[5:0];
            fine_delay_o   <= RST_FINE_SETPOINT;
        end else begin
            coarse_delay_o <= coarse_q;
            fine_delay_o   <= fine_q;
        end
    end

    // Readback capture only on a zero-to-one request write
    logic rb_capture;
    assign rb_capture = wr_stb && wr_addr == ADDR_READBACK_REQUEST && wr_data[0] && !rb_req_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            coarse_delay_readback_q <= RST_ZERO[5:0];
            fine_delay_readback_q   <= RST_ZERO;
            phase_readback_value_q  <= RST_ZERO[4:0];
        end else if (rb_capture) begin
            coarse_delay_readback_q <= coarse_q;
            fine_delay_readback_q   <= fine_q;
            phase_readback_value_q  <= phase_now;
        end
    end

    // Checks
    chk_open_loop_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !enable ##1 !enable |=> coarse_delay_o == $past(coarse_set_q, 2))
        else $error("Open loop coarse does not follow setpoint");
    chk_fail_cleared_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(fail_q) |-> state_q inside {ST_SEARCH, ST_FAIL} && !$past(in_band))
        else $error("Fail flag raised without failed search");
    chk_lost_on_drop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lost_evt |=> lost_q)
        else $error("Lost lock not flagged");
    chk_locked_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !enable |=> !locked_o)
        else $error("Locked while controller disabled");
    chk_coarse_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb && wr_addr == ADDR_COARSE_SETPOINT |=> coarse_set_q == $past(wr_data[5:0]))
        else $error("Coarse setpoint write lost");
    chk_fine_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_stb && wr_addr == ADDR_FINE_SETPOINT |=> fine_set_q == $past(wr_data))
        else $error("Fine setpoint write lost");
    chk_readback_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rb_capture |=> fine_delay_readback_q == $past(fine_q)
                    && coarse_delay_readback_q == $past(coarse_q))
        else $error("Readback not captured on request edge");
    chk_readback_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !rb_capture |=> $stable(coarse_delay_readback_q) && $stable(fine_delay_readback_q))
        else $error("Readback changed without request");
    chk_lost_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lost_q && !lost_clr |=> lost_q)
        else $error("Lost lock flag cleared without write");
    cov_lock: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(locked_o));
    cov_lost: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(lost_q));
    cov_capture: cover property (@(posedge clk_i) disable iff (sys_rst_i) rb_capture);
endmodule : dcl_ctrl

/* common/dcl_pkg.sv */
// Constants for the converter clock delay-lock controller
package dcl_pkg;
    // Register addresses on the serial configuration port
    localparam logic [14:0] ADDR_LOOP_CONTROL      = 15'h0091;
    localparam logic [14:0] ADDR_LOCK_STATUS       = 15'h0092;
    localparam logic [14:0] ADDR_SEARCH_GUARD_BAND = 15'h0093;
    localparam logic [14:0] ADDR_COARSE_SETPOINT   = 15'h0094;
    localparam logic [14:0] ADDR_FINE_SETPOINT     = 15'h0095;
    localparam logic [14:0] ADDR_TARGET_PHASE      = 15'h0096;
    localparam logic [14:0] ADDR_LOOP_BANDWIDTH    = 15'h0097;
    localparam logic [14:0] ADDR_READBACK_REQUEST  = 15'h0098;
    localparam logic [14:0] ADDR_COARSE_READBACK   = 15'h0099;
    localparam logic [14:0] ADDR_FINE_READBACK     = 15'h009A;
    localparam logic [14:0] ADDR_PHASE_READBACK    = 15'h009B;
    // Reset values
    localparam logic [7:0]  RST_LOOP_CONTROL       = 8'hF0;
    localparam logic [7:0]  RST_ZERO               = 8'h00;
    localparam logic [7:0]  RST_FINE_SETPOINT      = 8'h80;
    localparam logic [4:0]  RST_DESIRED_PHASE      = 5'h08;
    // Field positions of loop_control
    localparam int          CTL_ENABLE_BIT         = 0;
    localparam int          CTL_MODE_LSB           = 1;
    localparam int          CTL_SEARCH_LSB         = 3;
    localparam int          CTL_SLOPE_BIT          = 5;
    localparam int          CTL_SEARCH_ERR_BIT     = 6;
    localparam int          CTL_TRACK_ERR_BIT      = 7;
    // Field positions of lock_status
    localparam int          STS_LOCKED_BIT         = 0;
    localparam int          STS_LOST_BIT           = 1;
    localparam int          STS_FAIL_BIT           = 2;
    // Field positions of loop_bandwidth
    localparam int          BW_WEIGHT_LSB          = 0;
    localparam int          BW_FILT_LSB            = 2;
    // Controller modes
    localparam logic [1:0]  MODE_SEARCH_TRACK      = 2'h0;
    localparam logic [1:0]  MODE_TRACK_ONLY        = 2'h1;
    localparam logic [1:0]  MODE_SEARCH_ONLY       = 2'h2;
    // Serial frame: 16 instruction bits then 8 data bits
    localparam logic [4:0]  SPI_LAST_INSTR_BIT     = 5'h0F;
    localparam logic [4:0]  SPI_LAST_DATA_BIT      = 5'h17;
    // Controller update rate, in clock cycles between steps
    localparam logic [3:0]  UPDATE_DIV_CYC         = 4'h8;
    // Top of the coarse range; an upward search gives up on reaching it
    localparam logic [5:0]  COARSE_MAX             = 6'h3F;
    // Controller states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SEARCH = 2'b01,
        ST_TRACK  = 2'b10,
        ST_FAIL   = 2'b11
    } dcl_state_e;
endpackage : dcl_pkg

/* tb/dcl_ctrl_bench.sv */
// Self-checking bench for the delay-lock controller and its serial registers
`timescale 1ns/1ps
module dcl_ctrl_bench;
    import dcl_pkg::*;

    localparam int          LIMIT_CYC = 40000;
    localparam logic [14:0] ADDR_NONE = 15'h00A0;
    localparam logic [7:0]  RST_TAB [11] = '{RST_LOOP_CONTROL, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_FINE_SETPOINT, {3'h0, RST_DESIRED_PHASE}, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO};
    localparam logic [14:0] RW_ADDR [6] = '{ADDR_LOOP_CONTROL, ADDR_SEARCH_GUARD_BAND,
        ADDR_COARSE_SETPOINT, ADDR_FINE_SETPOINT, ADDR_TARGET_PHASE, ADDR_LOOP_BANDWIDTH};
    localparam logic [7:0]  RW_MASK [6] = '{8'hFE, 8'h0F, 8'h3F, 8'hFF, 8'h1F, 8'h1F};

    logic       clk_i = 1'b0;
    logic       sys_rst_i;
    logic       spi_cs_n_i;
    logic       spi_sclk_i;
    logic       spi_sdi_i;
    logic       spi_sdo_o;
    logic       spi_sdo_oe_o;
    logic [4:0] phase_meas_i;
    logic [5:0] coarse_delay_o;
    logic [7:0] fine_delay_o;
    logic       locked_o;
    logic [7:0] rd_data;
    logic       rd_done;
    logic [7:0] exp_q [$];
    int         miscompares = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #12.5 clk_i = ~clk_i;

    dcl_ctrl dcl_ctrl_i (
        .clk_i          (clk_i),
        .sys_rst_i      (sys_rst_i),
        .spi_cs_n_i     (spi_cs_n_i),
        .spi_sclk_i     (spi_sclk_i),
        .spi_sdi_i      (spi_sdi_i),
        .spi_sdo_o      (spi_sdo_o),
        .spi_sdo_oe_o   (spi_sdo_oe_o),
        .phase_meas_i   (phase_meas_i),
        .coarse_delay_o (coarse_delay_o),
        .fine_delay_o   (fine_delay_o),
        .locked_o       (locked_o)
    );

    task automatic end_sim();
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask : cmp_out

    // Sclk stays low three clk and high four so the design's edge detector sees it cleanly
    task automatic spi_frame(input logic rd, input logic [14:0] addr, input logic [7:0] wdat,
                             output logic [7:0] rdat);
        logic [23:0] fr;
        fr   = {rd, addr, wdat};
        rdat = 8'h00;
        @(posedge clk_i) spi_cs_n_i <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_i);
            spi_sclk_i <= 1'b0;
            spi_sdi_i  <= fr[i];
            repeat (3) @(posedge clk_i);
            spi_sclk_i <= 1'b1;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            if (i < 8) rdat[i] = spi_sdo_o;
            if (i == 0) cmp_out({7'h00, spi_sdo_oe_o}, {7'h00, rd});
        end
        @(posedge clk_i) spi_sclk_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        spi_cs_n_i <= 1'b1;
        spi_sdi_i  <= ~spi_sdi_i;
        repeat (4) @(posedge clk_i);
        cmp_out({7'h00, spi_sdo_oe_o}, 8'h00);
    endtask : spi_frame

    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        spi_frame(1'b0, addr, data, unused);
    endtask : wr

    // The expected byte is queued first; the watcher pairs it with the read result
    task automatic rd_chk(input logic [14:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        spi_frame(1'b1, addr, 8'h00, rd_data);
        rd_done <= 1'b1;
        @(posedge clk_i) rd_done <= 1'b0;
    endtask : rd_chk

    task automatic wait_lock(input logic want);
        int n;
        n = 0;
        while (locked_o !== want && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        cmp_out({7'h00, locked_o}, {7'h00, want});
    endtask : wait_lock

    always @(posedge clk_i) begin
        if (rd_done === 1'b1) cmp_reg(rd_data, exp_q.pop_front());
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == LIMIT_CYC) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        logic [7:0] r, c, f, c2, f2;
        sys_rst_i    = 1'b1;
        spi_cs_n_i   = 1'b1;
        spi_sclk_i   = 1'b0;
        spi_sdi_i    = 1'b0;
        phase_meas_i = 5'h08;
        rd_done      = 1'b0;
        void'($urandom(60));
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        cmp_out({2'b00, coarse_delay_o}, 8'h00);
        cmp_out(fine_delay_o, 8'h80);
        cmp_out({7'h00, locked_o}, 8'h00);
        for (int k = 0; k < 11; k++) rd_chk(ADDR_LOOP_CONTROL + 15'(k), RST_TAB[k]);
        rd_chk(ADDR_NONE, 8'h00);
        for (int k = 0; k < 6; k++) begin
            r = 8'($urandom) & RW_MASK[k];
            wr(RW_ADDR[k], r);
            rd_chk(RW_ADDR[k], r);
        end
        // Read-only places and an unmapped address must ignore writes
        wr(ADDR_COARSE_READBACK, 8'hFF);
        wr(ADDR_FINE_READBACK, 8'hFF);
        wr(ADDR_LOCK_STATUS, 8'hFF);
        wr(ADDR_NONE, 8'hFF);
        rd_chk(ADDR_COARSE_READBACK, 8'h00);
        rd_chk(ADDR_FINE_READBACK, 8'h00);
        rd_chk(ADDR_LOCK_STATUS, 8'h00);
        rd_chk(ADDR_NONE, 8'h00);
        // Open loop: outputs follow the setpoints
        c = 8'($urandom) & 8'h3F;
        f = 8'($urandom);
        wr(ADDR_COARSE_SETPOINT, c);
        wr(ADDR_FINE_SETPOINT, f);
        cmp_out({2'b00, coarse_delay_o}, c);
        cmp_out(fine_delay_o, f);
        wr(ADDR_READBACK_REQUEST, 8'h01);
        rd_chk(ADDR_COARSE_READBACK, c);
        rd_chk(ADDR_FINE_READBACK, f);
        rd_chk(ADDR_PHASE_READBACK, 8'h08);
        c2 = c ^ 8'h15;
        f2 = ~f;
        wr(ADDR_COARSE_SETPOINT, c2);
        wr(ADDR_FINE_SETPOINT, f2);
        wr(ADDR_READBACK_REQUEST, 8'h01);
        rd_chk(ADDR_COARSE_READBACK, c);
        rd_chk(ADDR_FINE_READBACK, f);
        wr(ADDR_READBACK_REQUEST, 8'h00);
        wr(ADDR_READBACK_REQUEST, 8'h01);
        rd_chk(ADDR_COARSE_READBACK, c2);
        rd_chk(ADDR_FINE_READBACK, f2);
        // Closed loop on a steady in-band phase, then drive it out of band
        wr(ADDR_SEARCH_GUARD_BAND, 8'h02);
        wr(ADDR_LOOP_BANDWIDTH, 8'h00);
        wr(ADDR_TARGET_PHASE, 8'h08);
        wr(ADDR_LOOP_CONTROL, 8'hC1);
        wait_lock(1'b1);
        rd_chk(ADDR_LOCK_STATUS, 8'h01);
        @(posedge clk_i) phase_meas_i <= 5'($urandom_range(3));
        wait_lock(1'b0);
        repeat (1500) @(posedge clk_i);
        rd_chk(ADDR_LOCK_STATUS, 8'h06);
        wr(ADDR_LOCK_STATUS, 8'h02);
        rd_chk(ADDR_LOCK_STATUS, 8'h06);
        wr(ADDR_LOCK_STATUS, 8'h00);
        rd_chk(ADDR_LOCK_STATUS, 8'h04);
        @(posedge clk_i) phase_meas_i <= 5'h08;
        wait_lock(1'b1);
        rd_chk(ADDR_LOCK_STATUS, 8'h01);
        wr(ADDR_LOOP_CONTROL, 8'hC0);
        @(negedge clk_i);
        cmp_out({2'b00, coarse_delay_o}, c2);
        cmp_out(fine_delay_o, f2);
        // Search-only mode: lock must drop once the phase leaves the band
        wr(ADDR_LOOP_CONTROL, 8'hC5);
        wait_lock(1'b1);
        @(posedge clk_i) phase_meas_i <= 5'($urandom_range(3));
        wait_lock(1'b0);
        repeat (1500) @(posedge clk_i);
        rd_chk(ADDR_LOCK_STATUS, 8'h06);
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule : dcl_ctrl_bench
